// [core/vru_vectored_request_unit.sv]
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [R1] sort requests: fast, vectored, default
// [R2] fast beats every normal request
// [R3] any fast request drives fast line
// [R4] readable word of active fast sources
// [R5] sixteen slots, any channel per slot
// [R6] lower slot number wins
// [R7] vectored above default, default lowest
// [R8] normal line on any normal request
// [R9] vector: best slot address or default
// [R10] readable word of active normal sources
// [R11] one request line per peripheral
// [R12] watchdog channel 0, channel 1 software
// [R13] timers on channels 4 and 5
// [R14] serial ports on channels 6 and 7
// [R15] modem status only on channel 7
// [R16] pwm 8, two-wire 9, sync 10/11
// [R17] lock flag 12, rtc flags 13
// [R18] externals 14..17, converter 18
// [R19] merged acceptance filters on 19
// [R20] message controllers tx/rx 20..27
// [R21] level requests, recomputed every cycle
module vru_vectored_request_unit
	import vru_pkg::*;
#(
	parameter int NUM_SLOTS = VRU_NUM_SLOTS,
	parameter int ADDR_BITS = VRU_ADDR_BITS
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	// peripheral flags
	input wire logic i_watchdog_event_flag,
	input wire logic i_debug_channel_receive,
	input wire logic i_debug_channel_transmit,

	// timers: match and capture flags share a channel
	input wire logic [3:0] i_timer0_match_flags,
	input wire logic [3:0] i_timer0_capture_flags,
	input wire logic [3:0] i_timer1_match_flags,
	input wire logic [3:0] i_timer1_capture_flags,

	// serial ports
	input wire logic i_serial0_receive_line_status_flag,
	input wire logic i_serial0_transmit_holding_empty_flag,
	input wire logic i_serial0_receive_data_ready_flag,
	input wire logic i_serial0_char_timeout_flag,
	input wire logic i_serial1_receive_line_status_flag,
	input wire logic i_serial1_transmit_holding_empty_flag,
	input wire logic i_serial1_receive_data_ready_flag,
	input wire logic i_serial1_char_timeout_flag,
	input wire logic i_serial1_modem_status_flag,

	// pwm, two-wire and sync ports
	input wire logic [6:0] i_pwm_match_flags,
	input wire logic i_two_wire_state_flag,
	input wire logic i_sync0_transfer_done_flag,
	input wire logic i_sync0_mode_fault_flag,
	input wire logic i_sync1_transfer_done_flag,
	input wire logic i_sync1_mode_fault_flag,

	// clock sources
	input wire logic i_loop_lock_flag,
	input wire logic i_clock_increment_flag,
	input wire logic i_clock_alarm_flag,

	// external pins, converter, message bus
	input wire logic [VRU_NUM_EXT-1:0] i_external_requests,
	input wire logic i_converter_request,
	input wire logic i_acceptance_filter_request,
	input wire logic [VRU_NUM_MSG-1:0] i_msg_transmit_requests,
	input wire logic [VRU_NUM_MSG-1:0] i_msg_receive_requests,

	// configuration
	input wire logic [VRU_NUM_CHANNELS-1:0] i_soft_requests,
	input wire logic [VRU_NUM_CHANNELS-1:0] i_channel_enable,
	input wire logic [VRU_NUM_CHANNELS-1:0] i_fast_select,
	input wire logic [NUM_SLOTS-1:0] i_slot_enable,
	input wire logic [NUM_SLOTS*VRU_CH_BITS-1:0] i_slot_channels,
	input wire logic [NUM_SLOTS*ADDR_BITS-1:0] i_slot_addresses,
	input wire logic [ADDR_BITS-1:0] i_default_address,

	// to the core and status
	output logic o_fast_request_line,
	output logic o_normal_request_line,
	output logic [VRU_NUM_CHANNELS-1:0] o_raw_status,
	output logic [VRU_NUM_CHANNELS-1:0] o_fast_status,
	output logic [VRU_NUM_CHANNELS-1:0] o_normal_status,
	output logic [ADDR_BITS-1:0] o_vector_address,
	output logic o_vector_hit,
	output logic [VRU_SLOT_BITS-1:0] o_vector_slot
);

	// ----------------------------------------
	// channel assembly
	// ----------------------------------------
	// one bit per channel; each bit has exactly one source below
	wire logic [VRU_NUM_CHANNELS-1:0] hw_requests;
	wire logic [VRU_NUM_CHANNELS-1:0] raw_requests;
	wire logic timer0_any;
	wire logic timer1_any;
	wire logic serial0_any;
	wire logic serial1_any;

	// [R13] every match and capture flag of a timer
	assign timer0_any = |{i_timer0_match_flags, i_timer0_capture_flags};
	assign timer1_any = |{i_timer1_match_flags, i_timer1_capture_flags};

	assign serial0_any = i_serial0_receive_line_status_flag
		| i_serial0_transmit_holding_empty_flag
		| i_serial0_receive_data_ready_flag
		| i_serial0_char_timeout_flag;
	// [R15] modem flag second port
	assign serial1_any = i_serial1_receive_line_status_flag
		| i_serial1_transmit_holding_empty_flag
		| i_serial1_receive_data_ready_flag
		| i_serial1_char_timeout_flag
		| i_serial1_modem_status_flag;

	// [R12] watchdog, software-only channel
	assign hw_requests[VRU_CH_WATCHDOG] = i_watchdog_event_flag;
	assign hw_requests[VRU_CH_SOFT_ONLY] = 1'b0;
	assign hw_requests[VRU_CH_DEBUG_RX] = i_debug_channel_receive;
	assign hw_requests[VRU_CH_DEBUG_TX] = i_debug_channel_transmit;

	// [R13] merged timer flags
	assign hw_requests[VRU_CH_TIMER0] = timer0_any;
	assign hw_requests[VRU_CH_TIMER1] = timer1_any;

	// [R14] serial port channels
	assign hw_requests[VRU_CH_SERIAL0] = serial0_any;
	assign hw_requests[VRU_CH_SERIAL1] = serial1_any;

	// [R16] pwm, two-wire, sync ports
	assign hw_requests[VRU_CH_PWM] = |i_pwm_match_flags;
	assign hw_requests[VRU_CH_TWO_WIRE] = i_two_wire_state_flag;
	assign hw_requests[VRU_CH_SYNC0] = i_sync0_transfer_done_flag | i_sync0_mode_fault_flag;
	assign hw_requests[VRU_CH_SYNC1] = i_sync1_transfer_done_flag | i_sync1_mode_fault_flag;

	// [R17] lock and clock flags
	assign hw_requests[VRU_CH_LOOP_LOCK] = i_loop_lock_flag;
	assign hw_requests[VRU_CH_RTC] = i_clock_increment_flag | i_clock_alarm_flag;

	// [R18] converter channel
	assign hw_requests[VRU_CH_ADC] = i_converter_request;

	// [R19] merged acceptance filters
	assign hw_requests[VRU_CH_ACCEPT] = i_acceptance_filter_request;

	// spare channels carry software requests only
	assign hw_requests[VRU_NUM_CHANNELS-1:VRU_CH_UNUSED_BASE] = '0;

	genvar gi;
	generate
		for (gi = 0; gi < VRU_NUM_EXT; gi++)
		begin : g_ext
			// [R18] externals in ascending order
			assign hw_requests[VRU_CH_EXT_BASE+gi] = i_external_requests[gi];
		end
		for (gi = 0; gi < VRU_NUM_MSG; gi++)
		begin : g_msg
			// [R20] transmit even, receive odd
			assign hw_requests[VRU_CH_MSG_BASE+2*gi] = i_msg_transmit_requests[gi];
			assign hw_requests[VRU_CH_MSG_BASE+2*gi+1] = i_msg_receive_requests[gi];
		end
	endgenerate

	// [R11] one line per peripheral; [R21] levels, no latching
	assign raw_requests = hw_requests | i_soft_requests;

	// ----------------------------------------
	// classification
	// ----------------------------------------
	wire logic [VRU_NUM_CHANNELS-1:0] active_requests;
	wire logic [VRU_NUM_CHANNELS-1:0] fast_requests;
	wire logic [VRU_NUM_CHANNELS-1:0] normal_requests;
	wire logic [NUM_SLOTS-1:0] slot_hits;

	// a disabled channel still shows in the raw word but reaches neither class
	assign active_requests = raw_requests & i_channel_enable;
	// [R1] fast class split off
	assign fast_requests = active_requests & i_fast_select;
	// [R2] fast channels never reach normal
	assign normal_requests = active_requests & ~i_fast_select;

	generate
		for (gi = 0; gi < NUM_SLOTS; gi++)
		begin : g_slot
			wire logic [VRU_CH_BITS-1:0] slot_channel;
			assign slot_channel = i_slot_channels[gi*VRU_CH_BITS +: VRU_CH_BITS];
			// a slot naming a fast channel never hits, so the vector stays normal-only
			// [R5] any channel in any slot
			assign slot_hits[gi] = i_slot_enable[gi] & normal_requests[slot_channel];
		end
	endgenerate

	// ----------------------------------------
	// request summaries
	// ----------------------------------------
	wire logic any_fast;
	wire logic any_normal;

	// [R3] fast requests merged
	assign any_fast = |fast_requests;
	// [R8] any vectored or default request
	assign any_normal = |normal_requests;

	// ----------------------------------------
	// slot priority
	// ----------------------------------------
	// chain entry n holds the winner among slots n and above; entry NUM_SLOTS is the default
	// a linear chain is sixteen muxes deep, which is short enough at this clock
	wire logic [NUM_SLOTS:0] chain_hit;
	wire logic [ADDR_BITS-1:0] chain_address [NUM_SLOTS+1];
	wire logic [VRU_SLOT_BITS-1:0] chain_slot [NUM_SLOTS+1];
	wire logic [ADDR_BITS-1:0] next_vector_address;
	wire logic [VRU_SLOT_BITS-1:0] next_vector_slot;
	wire logic next_vector_hit;

	assign chain_hit[NUM_SLOTS] = 1'b0;
	assign chain_address[NUM_SLOTS] = i_default_address;
	assign chain_slot[NUM_SLOTS] = VRU_SLOT_RESET;

	generate
		for (gi = 0; gi < NUM_SLOTS; gi++)
		begin : g_chain
			wire logic [ADDR_BITS-1:0] slot_address;
			assign slot_address = i_slot_addresses[gi*ADDR_BITS +: ADDR_BITS];
			// [R6] lower slot overrides higher
			assign chain_hit[gi] = slot_hits[gi] | chain_hit[gi+1];
			assign chain_address[gi] = slot_hits[gi] ? slot_address : chain_address[gi+1];
			assign chain_slot[gi] = slot_hits[gi] ? VRU_SLOT_BITS'(gi) : chain_slot[gi+1];
		end
	endgenerate

	assign next_vector_address = chain_address[0];
	assign next_vector_slot = chain_slot[0];
	assign next_vector_hit = chain_hit[0];

	// ----------------------------------------
	// request lines to the core
	// ----------------------------------------
	// [R21] recomputed every cycle; one cycle of latency keeps the lines glitch free
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_fast_request_line <= 1'b0;
			o_normal_request_line <= 1'b0;
		end
		else
		begin
			// [R2] fast line ignores normal work
			o_fast_request_line <= any_fast;
			o_normal_request_line <= any_normal;
		end
	end

	// ----------------------------------------
	// status words
	// ----------------------------------------
	// raw word is taken before the enable so software sees masked sources too
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_raw_status <= VRU_STATUS_RESET;
			o_fast_status <= VRU_STATUS_RESET;
			o_normal_status <= VRU_STATUS_RESET;
		end
		else
		begin
			o_raw_status <= raw_requests;
			// [R4] fast source word
			o_fast_status <= fast_requests;
			// [R10] normal source word
			o_normal_status <= normal_requests;
		end
	end

	// ----------------------------------------
	// vector
	// ----------------------------------------
	// the address stands even with no request, so a late read still lands on the default handler
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_vector_address <= ADDR_BITS'(VRU_ADDR_RESET);
			o_vector_hit <= 1'b0;
			o_vector_slot <= VRU_SLOT_RESET;
		end
		else
		begin
			// [R9] best slot address or default; [R7] vectored over default
			o_vector_address <= next_vector_address;
			o_vector_hit <= next_vector_hit;
			o_vector_slot <= next_vector_slot;
		end
	end

endmodule

`default_nettype wire

// [core/vru_pkg.sv]
package vru_pkg;
	localparam int VRU_NUM_CHANNELS = 32;
	localparam int VRU_NUM_SLOTS = 16;
	localparam int VRU_CH_BITS = 5;
	localparam int VRU_ADDR_BITS = 32;
	localparam int VRU_SLOT_BITS = 4;
	localparam logic [31:0] VRU_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] VRU_ADDR_RESET = 32'h0000_0000;
	localparam logic [3:0] VRU_SLOT_RESET = 4'h0;
	// channel map
	localparam int VRU_CH_WATCHDOG = 0;
	localparam int VRU_CH_SOFT_ONLY = 1;
	localparam int VRU_CH_DEBUG_RX = 2;
	localparam int VRU_CH_DEBUG_TX = 3;
	localparam int VRU_CH_TIMER0 = 4;
	localparam int VRU_CH_TIMER1 = 5;
	localparam int VRU_CH_SERIAL0 = 6;
	localparam int VRU_CH_SERIAL1 = 7;
	localparam int VRU_CH_PWM = 8;
	localparam int VRU_CH_TWO_WIRE = 9;
	localparam int VRU_CH_SYNC0 = 10;
	localparam int VRU_CH_SYNC1 = 11;
	localparam int VRU_CH_LOOP_LOCK = 12;
	localparam int VRU_CH_RTC = 13;
	localparam int VRU_CH_EXT_BASE = 14;
	localparam int VRU_CH_ADC = 18;
	localparam int VRU_CH_ACCEPT = 19;
	localparam int VRU_CH_MSG_BASE = 20;
	localparam int VRU_NUM_EXT = 4;
	localparam int VRU_NUM_MSG = 4;
	localparam int VRU_CH_UNUSED_BASE = 28;
endpackage

// [bench/vru_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module vru_chk
	import vru_pkg::*;
#(
	parameter int NUM_SLOTS = VRU_NUM_SLOTS,
	parameter int ADDR_BITS = VRU_ADDR_BITS
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [VRU_NUM_CHANNELS-1:0] i_channel_enable,
	input wire logic [VRU_NUM_CHANNELS-1:0] i_fast_select,
	input wire logic [NUM_SLOTS*VRU_CH_BITS-1:0] i_slot_channels,
	input wire logic [NUM_SLOTS*ADDR_BITS-1:0] i_slot_addresses,
	input wire logic [ADDR_BITS-1:0] i_default_address,
	input wire logic o_fast_request_line,
	input wire logic o_normal_request_line,
	input wire logic [VRU_NUM_CHANNELS-1:0] o_raw_status,
	input wire logic [VRU_NUM_CHANNELS-1:0] o_fast_status,
	input wire logic [VRU_NUM_CHANNELS-1:0] o_normal_status,
	input wire logic [ADDR_BITS-1:0] o_vector_address,
	input wire logic o_vector_hit,
	input wire logic [VRU_SLOT_BITS-1:0] o_vector_slot
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_fast_line; o_fast_request_line == |o_fast_status; endproperty
	a_fast_line: assert property (p_fast_line) else $error("fast line mismatch");
	property p_norm_line; o_normal_request_line == |o_normal_status; endproperty
	a_norm_line: assert property (p_norm_line) else $error("normal line mismatch");
	property p_split; (o_fast_status & o_normal_status) == 32'h0; endproperty
	a_split: assert property (p_split) else $error("channel in two classes");
	property p_fast_st; o_fast_status == (o_raw_status & $past(i_fast_select & i_channel_enable)); endproperty
	a_fast_st: assert property (p_fast_st) else $error("fast status mismatch");
	property p_norm_st; o_normal_status == (o_raw_status & $past(~i_fast_select & i_channel_enable)); endproperty
	a_norm_st: assert property (p_norm_st) else $error("normal status mismatch");
	// outputs still hold reset values at the first edge after release
	property p_dflt; $past(i_resetn) && !o_vector_hit |-> o_vector_address == $past(i_default_address); endproperty
	a_dflt: assert property (p_dflt) else $error("default address mismatch");
	property p_hit_addr; o_vector_hit |-> o_vector_address == ADDR_BITS'($past(i_slot_addresses) >> (o_vector_slot * ADDR_BITS)); endproperty
	a_hit_addr: assert property (p_hit_addr) else $error("slot address mismatch");
	property p_hit_src; o_vector_hit |-> o_normal_request_line && o_normal_status[VRU_CH_BITS'($past(i_slot_channels) >> (o_vector_slot * VRU_CH_BITS))]; endproperty
	a_hit_src: assert property (p_hit_src) else $error("winning slot not active");
endmodule
`default_nettype wire

// [bench/vru_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module vru_core_model
#(
	parameter int ADDR_BITS = 32
)
(
	input wire logic i_clk,
	input wire logic i_fast,
	input wire logic i_normal,
	input wire logic [ADDR_BITS-1:0] i_vector,
	output logic o_in_fast,
	output logic [ADDR_BITS-1:0] o_taken_vector
);
	always_ff @(posedge i_clk)
	begin
		o_in_fast <= i_fast;
		if (!i_fast && i_normal)
			o_taken_vector <= i_vector;
	end
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0, i_resetn = 1'b0, in_fast, o_fast_request_line, o_normal_request_line, o_vector_hit;
	logic [31:0] r = 32'h0, m = 32'h0, i_soft_requests = 32'h0, i_channel_enable = 32'hffff_ffff, i_fast_select = 32'h0;
	logic [31:0] i_default_address = 32'hdead_0000, o_raw_status, o_fast_status, o_normal_status, o_vector_address, taken;
	logic [15:0] i_slot_enable = 16'h0;
	logic [79:0] i_slot_channels = 80'h0;
	logic [511:0] i_slot_addresses = 512'h0;
	logic [3:0] o_vector_slot;
	int error_cnt = 0, check_count = 0;
	int mc[9] = '{4, 5, 6, 7, 8, 10, 11, 13, 1};
	// one line per peripheral, several flags merged
	wire logic i_watchdog_event_flag = r[0], i_debug_channel_receive = r[2], i_debug_channel_transmit = r[3];
	wire logic [3:0] i_timer0_match_flags = {3'h0, r[4]}, i_timer0_capture_flags = {m[4], 3'h0};
	wire logic [3:0] i_timer1_match_flags = {r[5], 3'h0}, i_timer1_capture_flags = {3'h0, m[5]};
	wire logic i_serial0_receive_line_status_flag = r[6], i_serial0_transmit_holding_empty_flag = m[6];
	wire logic i_serial0_receive_data_ready_flag = r[6], i_serial0_char_timeout_flag = m[6];
	wire logic i_serial1_receive_line_status_flag = r[7], i_serial1_transmit_holding_empty_flag = m[7];
	wire logic i_serial1_receive_data_ready_flag = r[7], i_serial1_char_timeout_flag = m[7];
	wire logic i_serial1_modem_status_flag = m[1], i_two_wire_state_flag = r[9], i_loop_lock_flag = r[12];
	wire logic [6:0] i_pwm_match_flags = {m[8], 5'h0, r[8]};
	wire logic i_sync0_transfer_done_flag = r[10], i_sync0_mode_fault_flag = m[10];
	wire logic i_sync1_transfer_done_flag = r[11], i_sync1_mode_fault_flag = m[11];
	wire logic i_clock_increment_flag = r[13], i_clock_alarm_flag = m[13];
	wire logic [3:0] i_external_requests = r[17:14];
	wire logic i_converter_request = r[18], i_acceptance_filter_request = r[19];
	wire logic [3:0] i_msg_transmit_requests = {r[26], r[24], r[22], r[20]};
	wire logic [3:0] i_msg_receive_requests = {r[27], r[25], r[23], r[21]};
	vru_vectored_request_unit uut (.*);
	vru_core_model #(.ADDR_BITS(32)) core (.i_clk(i_clk), .i_fast(o_fast_request_line),
		.i_normal(o_normal_request_line), .i_vector(o_vector_address), .o_in_fast(in_fast), .o_taken_vector(taken));
	initial forever #25 i_clk = ~i_clk;
	// ----------------------------------------
	// shared tasks and scenarios
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// outputs are registered: one edge after the inputs land
	task automatic put(input logic [31:0] rr, input logic [31:0] mm, input logic [31:0] ss);
		@(posedge i_clk);
		r <= rr;
		m <= mm;
		i_soft_requests <= ss;
		@(posedge i_clk);
		#1;
	endtask
	task automatic vec(input logic [31:0] rr, input logic [31:0] ss, input int s);
		put(rr, 32'h0, ss);
		chk("hit", o_vector_hit, s >= 0);
		chk("slot", o_vector_slot, (s < 0) ? 0 : s);
		chk("vector", o_vector_address, (s < 0) ? i_default_address : 32'h100 + s);
		chk("irq", o_normal_request_line, 32'h1);
	endtask
	task automatic t_map();
		for (int c = 0; c < 32; c++)
		begin
			if (c == 1 || c > 27)
				put(32'h0, 32'h0, 32'h1 << c);
			else
				put(32'h1 << c, 32'h0, 32'h0);
			chk("raw", o_raw_status, 32'h1 << c);
			chk("normal", o_normal_status, 32'h1 << c);
			chk("irq", o_normal_request_line, 32'h1);
		end
		foreach (mc[i])
		begin
			put(32'h0, 32'h1 << mc[i], 32'h0);
			chk("merged", o_raw_status, 32'h1 << ((mc[i] == 1) ? 7 : mc[i]));
		end
	endtask
	task automatic t_fast();
		@(posedge i_clk);
		i_fast_select <= 32'h0000_0011;
		i_channel_enable <= 32'hffff_fffb;
		put(32'h0000_0015, 32'h0, 32'h0000_0200);
		chk("fast line", o_fast_request_line, 32'h1);
		chk("fast word", o_fast_status, 32'h0000_0011);
		chk("normal", o_normal_status, 32'h0000_0200);
		@(posedge i_clk);
		#1;
		chk("core fast", in_fast, 32'h1);
	endtask
	task automatic t_prio();
		@(posedge i_clk);
		i_fast_select <= 32'h0000_0040;
		i_channel_enable <= 32'hffff_ffff;
		i_slot_enable <= 16'hffff;
		for (int s = 0; s < 16; s++)
		begin
			i_slot_channels[s*5 +: 5] <= 5'(s + 4);
			i_slot_addresses[s*32 +: 32] <= 32'h100 + 32'(s);
		end
		vec(32'h0000_2200, 32'h0, 5);
		vec(32'h0000_2040, 32'h0, 9);
		vec(32'h0, 32'h1000_0000, -1);
		vec(32'h0008_0000, 32'h0, 15);
		vec(32'h0008_0010, 32'h0, 0);
		@(posedge i_clk);
		#1;
		chk("core vector", taken, 32'h100);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_map();
		t_fast();
		t_prio();
		conclude();
	end
endmodule
bind vru_vectored_request_unit vru_chk #(.NUM_SLOTS(NUM_SLOTS), .ADDR_BITS(ADDR_BITS)) chk_i (.*);
`default_nettype wire
